/* design/apo_converter_end.sv */
// Digital end of the 14-bit sampling converter: sampling, pipeline, formatting and output pins.
// Assumes the encode clock and all static pins arrive asynchronously and are slow against clk_sys_in.
//
// Summary of operation
// - Sample held at rising encode edge
// - Receiver may capture on encode fall
// - Power-down high: stop, outputs high impedance
// - Dither pin high adds internal dither
// - Parallel word out, top bit MSB
// - Negative valid clock toggles; capture on fall
// - Positive valid clock inverse; capture on rise
// - Overflow flag high for out-of-range sample
// - Output enable low drives, high floats
// - Four-level mode selects format and stabiliser
// - Scramble: upper bits xor with LSB
// - Receiver undoes scramble with same xor
// - Gain pin selects gain one or 1.5
// - Result appears seven encode cycles later
// - Encode high when positive exceeds negative
`default_nettype none

module apo_converter_end (
  input  wire logic                          clk_sys_in,
  input  wire logic                          reset_n_in,
  input  wire logic                          clk_en_in,
  input  wire logic [apo_pkg::ANALOG_W-1:0]  analog_code_in,
  input  wire logic                          power_down_pin_in,
  input  wire logic                          dither_enable_in,
  input  wire logic                          output_enable_n_in,
  input  wire logic [1:0]                    mode_level_in,
  input  wire logic                          output_scramble_select_in,
  input  wire logic                          gain_range_select_in,
  output logic                               stabiliser_on_out,
  output logic                               powered_down_out,
  apo_link_if.dev                            link
);
  import apo_pkg::*;

  localparam int SYNC_W = 2 + ANALOG_W + 7;

  // Synchronised pins
  logic [SYNC_W-1:0]   pins_raw;
  logic [SYNC_W-1:0]   pins_sync;
  logic                enc_pos_s;
  logic                enc_neg_s;
  logic [ANALOG_W-1:0] analog_s;
  logic                power_down_s;
  logic                dither_s;
  logic                oe_n_s;
  logic [1:0]          mode_s;
  logic                scramble_s;
  logic                gain_s;

  assign pins_raw = {link.encode_pos, link.encode_neg, analog_code_in, power_down_pin_in,
                     dither_enable_in, output_enable_n_in, mode_level_in,
                     output_scramble_select_in, gain_range_select_in};

  apo_sync #(
    .W (SYNC_W)
  ) u_pin_sync (
    .clk_sys_in (clk_sys_in),
    .reset_n_in (reset_n_in),
    .clk_en_in  (clk_en_in),
    .async_in   (pins_raw),
    .sync_out   (pins_sync)
  );

  assign {enc_pos_s, enc_neg_s, analog_s, power_down_s, dither_s, oe_n_s, mode_s,
          scramble_s, gain_s} = pins_sync;

  // Encode phase and its edges
  logic enc_level;
  logic enc_level_reg;
  logic enc_rise;
  logic enc_fall;
  logic sample_take;

  assign enc_level   = enc_pos_s & ~enc_neg_s;
  assign enc_rise    = enc_level & ~enc_level_reg;
  assign enc_fall    = ~enc_level & enc_level_reg;
  assign sample_take = enc_rise & ~power_down_s;

  // Mode decode
  apo_mode_type mode_sel;
  logic         twos_mode;
  logic         dcs_on;

  assign mode_sel  = apo_mode_type'(mode_s);
  assign twos_mode = (mode_sel == APO_MODE_TC_DCS) || (mode_sel == APO_MODE_TC_NODCS);
  assign dcs_on    = (mode_sel == APO_MODE_OB_DCS) || (mode_sel == APO_MODE_TC_DCS);

  // Dither source
  logic [LFSR_W-1:0] lfsr_reg;
  logic [LFSR_W-1:0] lfsr_next;

  assign lfsr_next = lfsr_reg[0] ? ((lfsr_reg >> 1) ^ LFSR_TAPS) : (lfsr_reg >> 1);

  // Conversion of one held sample
  logic signed [17:0]         analog_ext;
  logic signed [17:0]         scaled;
  logic signed [17:0]         dithered;
  logic                       over_max;
  logic                       under_min;
  logic                       out_of_range;
  logic signed [17:0]         clamped;
  logic        [SAMPLE_W-1:0] offset_bin;
  logic        [SAMPLE_W-1:0] formatted;
  logic        [SAMPLE_W-1:0] scrambled;

  assign analog_ext   = 18'(signed'(analog_s));
  assign scaled       = gain_s ? (analog_ext + (analog_ext >>> 1)) : analog_ext;
  assign dithered     = dither_s ? (scaled + 18'(lfsr_reg[0])) : scaled;
  assign over_max     = dithered > CODE_MAX;
  assign under_min    = dithered < CODE_MIN;
  assign out_of_range = over_max | under_min;
  assign clamped      = over_max ? CODE_MAX :
                        under_min ? CODE_MIN : dithered;
  assign offset_bin   = clamped[SAMPLE_W-1:0] ^ MSB_MASK;
  assign formatted    = twos_mode ? (offset_bin ^ MSB_MASK) : offset_bin;
  assign scrambled    = scramble_s ? apo_scramble(formatted) : formatted;

  // Pipeline: a sample enters stage 0 at its own encode rise and
  // reaches the output register seven rises later
  logic [SAMPLE_W:0] pipe_reg [0:PIPE_LATENCY-1];
  logic [SAMPLE_W:0] out_word_reg;
  logic              dv_n_reg;
  logic              dv_p_reg;
  logic              oe_n_reg;

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      enc_level_reg <= 1'b0;
    end else if (clk_en_in) begin
      enc_level_reg <= enc_level;
    end
  end

  // Dither source steps once per sample taken
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      lfsr_reg <= LFSR_SEED;
    end else if (clk_en_in && sample_take) begin
      lfsr_reg <= lfsr_next;
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < PIPE_LATENCY; i++) begin
        pipe_reg[i] <= '0;
      end
    end else if (clk_en_in && sample_take) begin
      pipe_reg[0] <= {out_of_range, scrambled};
      for (int i = 1; i < PIPE_LATENCY; i++) begin
        pipe_reg[i] <= pipe_reg[i-1];
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      out_word_reg <= '0;
    end else if (clk_en_in && sample_take) begin
      out_word_reg <= pipe_reg[PIPE_LATENCY-1];
    end
  end

  // Valid clocks follow the encode phase; data changes as the negative clock rises
  // They keep running through power-down so no stale level meets the first new word
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dv_n_reg <= 1'b0;
      dv_p_reg <= 1'b1;
    end else if (clk_en_in) begin
      if (enc_rise) begin
        dv_n_reg <= 1'b1;
        dv_p_reg <= 1'b0;
      end else if (enc_fall) begin
        dv_n_reg <= 1'b0;
        dv_p_reg <= 1'b1;
      end
    end
  end

  // Output drivers and status pins
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      oe_n_reg <= 1'b1;
    end else if (clk_en_in) begin
      oe_n_reg <= power_down_s | oe_n_s;
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stabiliser_on_out <= 1'b0;
      powered_down_out  <= 1'b0;
    end else if (clk_en_in) begin
      stabiliser_on_out <= dcs_on;
      powered_down_out  <= power_down_s;
    end
  end

  assign link.sample_word_bits    = out_word_reg[SAMPLE_W-1:0];
  assign link.range_overflow_flag = out_word_reg[SAMPLE_W];
  assign link.data_valid_clock_n  = dv_n_reg;
  assign link.data_valid_clock_p  = dv_p_reg;
  assign link.outputs_oe_n        = oe_n_reg;

endmodule : apo_converter_end

`default_nettype wire

/* design/apo_link_if.sv */
// Pin-level link between the converter and the capturing receiver.
// Assumes no tri-state resolution inside; the enable travels as its own signal.
`default_nettype none

interface apo_link_if;
  import apo_pkg::*;

  logic                encode_pos;
  logic                encode_neg;
  logic [SAMPLE_W-1:0] sample_word_bits;
  logic                range_overflow_flag;
  logic                data_valid_clock_p;
  logic                data_valid_clock_n;
  logic                outputs_oe_n;

  modport dev (
    input  encode_pos,
    input  encode_neg,
    output sample_word_bits,
    output range_overflow_flag,
    output data_valid_clock_p,
    output data_valid_clock_n,
    output outputs_oe_n
  );

  modport rcv (
    output encode_pos,
    output encode_neg,
    input  sample_word_bits,
    input  range_overflow_flag,
    input  data_valid_clock_p,
    input  data_valid_clock_n,
    input  outputs_oe_n
  );

endinterface : apo_link_if

`default_nettype wire

/* design/apo_pkg.sv */
// Shared constants, types and helper functions for the converter output port.
// Assumes a 100 MHz system clock on both ends.
`default_nettype none

package apo_pkg;

  // Widths
  localparam int SAMPLE_W     = 14;
  localparam int ANALOG_W     = 16;
  localparam int PIPE_LATENCY = 7;
  localparam int LFSR_W       = 16;

  // Timing
  localparam int CLK_PERIOD_NS    = 10;
  localparam int ENC_PERIOD_NS    = 160;
  localparam int ENC_HALF_CYCLES  = (ENC_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
  localparam logic [7:0] ENC_HALF_LAST = 8'(ENC_HALF_CYCLES - 1);

  // Conversion limits in two's complement
  localparam logic signed [17:0] CODE_MAX = 18'sh0_1FFF;
  localparam logic signed [17:0] CODE_MIN = -18'sh0_2000;
  localparam logic [SAMPLE_W-1:0] MSB_MASK = 14'h2000;

  // Dither source
  localparam logic [LFSR_W-1:0] LFSR_SEED = 16'hACE1;
  localparam logic [LFSR_W-1:0] LFSR_TAPS = 16'hB400;

  // Four-level format and stabiliser select
  typedef enum logic [1:0] {
    APO_MODE_OB_NODCS  = 2'b00,
    APO_MODE_OB_DCS    = 2'b01,
    APO_MODE_TC_DCS    = 2'b11,
    APO_MODE_TC_NODCS  = 2'b10
  } apo_mode_type;

  // Receiver register map (byte addresses)
  localparam logic [3:0] REG_CTRL_OFS   = 4'h0;
  localparam logic [3:0] REG_STATUS_OFS = 4'h4;
  localparam logic [3:0] REG_MASK_OFS   = 4'h8;
  localparam logic [3:0] REG_DATA_OFS   = 4'hC;

  // Control fields
  localparam int CTRL_RUN_BIT     = 0;
  localparam int CTRL_DESCR_BIT   = 1;
  localparam int CTRL_USE_P_BIT   = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  // Status and mask fields
  localparam int STAT_CAPTURED_BIT = 0;
  localparam int STAT_OVERFLOW_BIT = 1;
  localparam logic [1:0] STAT_RESET = 2'h0;
  localparam logic [1:0] MASK_RESET = 2'h0;

  // Data register field
  localparam int DATA_OVF_BIT = 16;

  // Bits above the LSB xor-ed with the LSB; self-inverse
  function automatic logic [SAMPLE_W-1:0] apo_scramble(input logic [SAMPLE_W-1:0] w);
    apo_scramble = {w[SAMPLE_W-1:1] ^ {(SAMPLE_W-1){w[0]}}, w[0]};
  endfunction : apo_scramble

endpackage : apo_pkg

`default_nettype wire

/* design/apo_receiver_end.sv */
// Capturing receiver: makes the encode clock, captures words, exposes registers and an interrupt.
// Assumes a plain register port with read data one cycle after the read strobe.
`default_nettype none

module apo_receiver_end (
  input  wire logic        clk_sys_in,
  input  wire logic        reset_n_in,
  input  wire logic        clk_en_in,
  input  wire logic [3:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_write_in,
  input  wire logic        reg_read_in,
  output logic      [31:0] reg_rdata_out,
  output logic             irq_out,
  apo_link_if.rcv          link
);
  import apo_pkg::*;

  localparam int SYNC_W = SAMPLE_W + 4;

  logic [2:0]          ctrl_reg;
  logic [1:0]          status_reg;
  logic [1:0]          status_next;
  logic [1:0]          mask_reg;
  logic [SAMPLE_W:0]   data_reg;
  logic [7:0]          div_cnt_reg;
  logic                enc_reg;
  logic                enc_n_reg;

  // Encode clock divider
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      div_cnt_reg <= 8'h00;
      enc_reg     <= 1'b0;
      enc_n_reg   <= 1'b1;
    end else if (clk_en_in && ctrl_reg[CTRL_RUN_BIT]) begin
      if (div_cnt_reg == ENC_HALF_LAST) begin
        div_cnt_reg <= 8'h00;
        enc_reg     <= ~enc_reg;
        enc_n_reg   <= enc_reg;
      end else begin
        div_cnt_reg <= div_cnt_reg + 8'h01;
      end
    end
  end

  assign link.encode_pos = enc_reg;
  assign link.encode_neg = enc_n_reg;

  // Pin capture
  logic [SYNC_W-1:0]   pins_sync;
  logic [SAMPLE_W-1:0] word_s;
  logic                ovf_s;
  logic                dvp_s;
  logic                dvn_s;
  logic                oe_n_s;
  logic                dvp_prev_reg;
  logic                dvn_prev_reg;

  apo_sync #(
    .W (SYNC_W)
  ) u_pin_sync (
    .clk_sys_in (clk_sys_in),
    .reset_n_in (reset_n_in),
    .clk_en_in  (clk_en_in),
    .async_in   ({link.sample_word_bits, link.range_overflow_flag, link.data_valid_clock_p,
                  link.data_valid_clock_n, link.outputs_oe_n}),
    .sync_out   (pins_sync)
  );

  assign {word_s, ovf_s, dvp_s, dvn_s, oe_n_s} = pins_sync;

  logic                capture;
  logic [SAMPLE_W-1:0] word_dec;
  logic [1:0]          status_set;
  logic [1:0]          status_clr;

  assign capture  = ~oe_n_s & (ctrl_reg[CTRL_USE_P_BIT] ? (dvp_s & ~dvp_prev_reg)
                                                        : (~dvn_s & dvn_prev_reg));
  assign word_dec = ctrl_reg[CTRL_DESCR_BIT] ? apo_scramble(word_s) : word_s;

  // Set wins over a same-cycle write-one clear
  assign status_set  = {capture & ovf_s, capture};
  assign status_clr  = (reg_write_in && reg_addr_in == REG_STATUS_OFS) ? reg_wdata_in[1:0] : 2'b00;
  assign status_next = (status_reg & ~status_clr) | status_set;

  // Read mux
  logic [31:0] rd_mux;

  assign rd_mux = (reg_addr_in == REG_CTRL_OFS)   ? {29'h0000_0000, ctrl_reg}   :
                  (reg_addr_in == REG_STATUS_OFS) ? {30'h0000_0000, status_reg} :
                  (reg_addr_in == REG_MASK_OFS)   ? {30'h0000_0000, mask_reg}   :
                  (reg_addr_in == REG_DATA_OFS)   ? {15'h0000, data_reg[SAMPLE_W], 2'h0,
                                                     data_reg[SAMPLE_W-1:0]}  : 32'h0000_0000;

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dvp_prev_reg <= 1'b0;
      dvn_prev_reg <= 1'b0;
      data_reg     <= '0;
      status_reg   <= STAT_RESET;
    end else if (clk_en_in) begin
      dvp_prev_reg <= dvp_s;
      dvn_prev_reg <= dvn_s;
      status_reg   <= status_next;
      if (capture) begin
        data_reg <= {ovf_s, word_dec};
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctrl_reg      <= CTRL_RESET;
      mask_reg      <= MASK_RESET;
      reg_rdata_out <= 32'h0000_0000;
      irq_out       <= 1'b0;
    end else if (clk_en_in) begin
      if (reg_write_in && reg_addr_in == REG_CTRL_OFS) begin
        ctrl_reg <= reg_wdata_in[2:0];
      end
      if (reg_write_in && reg_addr_in == REG_MASK_OFS) begin
        mask_reg <= reg_wdata_in[1:0];
      end
      reg_rdata_out <= reg_read_in ? rd_mux : 32'h0000_0000;
      irq_out       <= |(status_next & mask_reg);
    end
  end

endmodule : apo_receiver_end

`default_nettype wire

/* design/apo_sync.sv */
// Two-flop synchroniser for a vector of inputs from outside the clock domain.
// Assumes each bit is a slow level; no bus coherency is promised.
`default_nettype none

module apo_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys_in,
  input  wire logic         reset_n_in,
  input  wire logic         clk_en_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else if (clk_en_in) begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : apo_sync

`default_nettype wire

/* testbench/apo_link_props.sv */
// Concurrent checks on the converter-to-receiver link.
// Assumes both ends share clk_sys_in and reset_n_in.
`default_nettype none

module apo_link_props
  import apo_pkg::*;
(
  input wire logic                clk_sys_in,
  input wire logic                reset_n_in,
  input wire logic                encode_pos,
  input wire logic [SAMPLE_W-1:0] sample_word_bits,
  input wire logic                range_overflow_flag,
  input wire logic                data_valid_clock_p,
  input wire logic                data_valid_clock_n,
  input wire logic                outputs_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!reset_n_in);

  valid_pair_a: assert property (data_valid_clock_p != data_valid_clock_n)
    else $error("valid clocks not complementary");
  valid_rise_a: assert property (
    $rose(encode_pos) && !outputs_oe_n |-> ##[2:6] (data_valid_clock_n || outputs_oe_n))
    else $error("valid clock missed encode rise");
  valid_fall_a: assert property (
    $fell(encode_pos) && !outputs_oe_n |-> ##[2:6] (!data_valid_clock_n || outputs_oe_n))
    else $error("valid clock missed encode fall");
  valid_hold_a: assert property ($rose(data_valid_clock_n) |-> data_valid_clock_n[*5])
    else $error("valid clock high phase too short");
  word_steady_a: assert property ($changed(sample_word_bits) |-> $rose(data_valid_clock_n))
    else $error("word changed off the valid edge");
  flag_steady_a: assert property ($changed(range_overflow_flag) |-> $rose(data_valid_clock_n))
    else $error("flag changed off the valid edge");
  flag_code_a: assert property (
    range_overflow_flag |-> sample_word_bits inside {14'h0000, 14'h0001, 14'h1FFF, 14'h2000, 14'h2001, 14'h3FFF})
    else $error("flag high on an in-range word");
  enc_high_a: assert property ($rose(encode_pos) |-> encode_pos[*8] ##1 !encode_pos)
    else $error("encode high phase wrong");
  enc_low_a: assert property ($fell(encode_pos) |-> !encode_pos[*8] ##1 encode_pos)
    else $error("encode low phase wrong");

  cover property ($rose(data_valid_clock_n));
  cover property (range_overflow_flag && !outputs_oe_n);
  cover property ($rose(outputs_oe_n));
endmodule : apo_link_props

`default_nettype wire

/* testbench/testbench.sv */
// Self-checking bench: converter end and receiver end joined by the link.
// Assumes both ends run from one 100 MHz clock with the clock enable held high.
`default_nettype none

module testbench import apo_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  logic                clk_sys_in;
  logic                reset_n_in;
  logic [ANALOG_W-1:0] code;
  logic                pd_pin;
  logic                dither_enable;
  logic                oe_n_pin;
  logic [1:0]          mode;
  logic                scr;
  logic                gain;
  logic                stab;
  logic                pdn;
  logic [3:0]          addr;
  logic [31:0]         wdata;
  logic [31:0]         rdata;
  logic                wr;
  logic                rd;
  logic                irq;
  int                  n_mismatch = 0;
  int                  cmp_count = 0;
  int                  cyc = 0;
  logic [15:0]         code_t [6] = '{16'h0064, 16'hFF9C, 16'h2328, 16'hE890, 16'h03E8, 16'h03E9};
  logic [1:0]          mode_t [6] = '{2'h0, 2'h3, 2'h1, 2'h2, 2'h3, 2'h0};
  logic [5:0]          gain_t = 6'h18;
  logic [5:0]          scr_t = 6'h30;
  logic [5:0]          dsc_t = 6'h10;

  apo_link_if link ();

  apo_converter_end i_apo_converter_end (
    .clk_sys_in                (clk_sys_in),
    .reset_n_in                (reset_n_in),
    .clk_en_in                 (1'b1),
    .analog_code_in            (code),
    .power_down_pin_in         (pd_pin),
    .dither_enable_in          (dither_enable),
    .output_enable_n_in        (oe_n_pin),
    .mode_level_in             (mode),
    .output_scramble_select_in (scr),
    .gain_range_select_in      (gain),
    .stabiliser_on_out         (stab),
    .powered_down_out          (pdn),
    .link                      (link.dev)
  );

  apo_receiver_end i_apo_receiver_end (
    .clk_sys_in    (clk_sys_in),
    .reset_n_in    (reset_n_in),
    .clk_en_in     (1'b1),
    .reg_addr_in   (addr),
    .reg_wdata_in  (wdata),
    .reg_write_in  (wr),
    .reg_read_in   (rd),
    .reg_rdata_out (rdata),
    .irq_out       (irq),
    .link          (link.rcv)
  );

  apo_link_props i_apo_link_props (
    .clk_sys_in          (clk_sys_in),
    .reset_n_in          (reset_n_in),
    .encode_pos          (link.encode_pos),
    .sample_word_bits    (link.sample_word_bits),
    .range_overflow_flag (link.range_overflow_flag),
    .data_valid_clock_p  (link.data_valid_clock_p),
    .data_valid_clock_n  (link.data_valid_clock_n),
    .outputs_oe_n        (link.outputs_oe_n)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys_in);
    wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk_sys_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_in);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : reg_rd

  // Expected DATA register: gain, clamp, then format
  function automatic logic [31:0] exp_data(input logic [15:0] c, input logic [1:0] m, input logic g);
    logic signed [17:0] v;
    logic [13:0]        w;
    logic               ov;
    v = 18'(signed'(c));
    if (g) v = v + (v >>> 1);
    ov = (v > CODE_MAX) || (v < CODE_MIN);
    if (v > CODE_MAX) v = CODE_MAX;
    if (v < CODE_MIN) v = CODE_MIN;
    w = v[13:0];
    if (!m[1]) w = w ^ MSB_MASK;
    return {15'h0, ov, 2'h0, w};
  endfunction : exp_data

  task automatic give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict

  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  initial begin
    logic [31:0] e;
    logic [13:0] w;
    int          hi;
    int          lo;
    code = 16'h0000;
    pd_pin = 1'b0;
    dither_enable = 1'b0;
    oe_n_pin = 1'b0;
    mode = 2'h0;
    scr = 1'b0;
    gain = 1'b0;
    addr = 4'h0;
    wdata = 32'h0000_0000;
    wr = 1'b0;
    rd = 1'b0;
    hi = 0;
    lo = 0;
    reset_n_in = 1'b0;
    repeat (2) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    reg_rd(REG_STATUS_OFS, 32'h0000_0000);
    reg_rd(REG_MASK_OFS, 32'h0000_0000);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_sys_in);
      code <= code_t[i];
      mode <= mode_t[i];
      gain <= gain_t[i];
      scr <= scr_t[i];
      reg_wr(REG_CTRL_OFS, {29'h0, 1'(i), dsc_t[i], 1'b1});
      repeat (200) @(posedge clk_sys_in);
      e = exp_data(code_t[i], mode_t[i], gain_t[i]);
      if (scr_t[i] && !dsc_t[i]) e[13:0] = e[13:0] ^ {{13{e[0]}}, 1'b0};
      reg_rd(REG_DATA_OFS, e);
      chk({31'h0, stab}, {31'h0, mode_t[i][0]});
    end
    @(posedge clk_sys_in);
    scr <= 1'b0;
    dither_enable <= 1'b1;
    code <= 16'h00C8;
    mode <= 2'h0;
    gain <= 1'b0;
    repeat (200) @(posedge clk_sys_in);
    for (int i = 0; i < 16; i++) begin
      @(posedge link.data_valid_clock_n);
      #1;
      w = link.sample_word_bits;
      if (w === 14'h20C9) hi++;
      if (w === 14'h20C8) lo++;
    end
    chk(32'(hi + lo), 32'h0000_0010);
    chk({31'h0, hi > 0 && lo > 0}, 32'h0000_0001);
    @(posedge clk_sys_in);
    dither_enable <= 1'b0;
    code <= 16'h0010;
    mode <= 2'h3;
    repeat (200) @(posedge clk_sys_in);
    @(negedge link.encode_pos);
    @(posedge clk_sys_in);
    code <= 16'h0020;
    for (int i = 0; i < 8; i++) begin
      @(posedge link.data_valid_clock_n);
      #1;
      if (i == 6) chk({18'h0, link.sample_word_bits}, 32'h0000_0010);
      if (i == 7) chk({18'h0, link.sample_word_bits}, 32'h0000_0020);
    end
    reg_wr(REG_MASK_OFS, 32'h0000_0001);
    repeat (40) @(posedge clk_sys_in);
    chk({31'h0, irq}, 32'h0000_0001);
    @(posedge clk_sys_in);
    pd_pin <= 1'b1;
    repeat (20) @(posedge clk_sys_in);
    w = link.sample_word_bits;
    reg_wr(REG_STATUS_OFS, 32'h0000_0003);
    repeat (40) @(posedge clk_sys_in);
    chk({31'h0, link.outputs_oe_n}, 32'h0000_0001);
    chk({31'h0, pdn}, 32'h0000_0001);
    chk({18'h0, link.sample_word_bits}, {18'h0, w});
    reg_rd(REG_STATUS_OFS, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    @(posedge clk_sys_in);
    pd_pin <= 1'b0;
    repeat (60) @(posedge clk_sys_in);
    reg_rd(REG_STATUS_OFS, 32'h0000_0001);
    @(posedge clk_sys_in);
    oe_n_pin <= 1'b1;
    repeat (20) @(posedge clk_sys_in);
    chk({31'h0, link.outputs_oe_n}, 32'h0000_0001);
    reg_wr(REG_STATUS_OFS, 32'h0000_0001);
    repeat (40) @(posedge clk_sys_in);
    reg_rd(REG_STATUS_OFS, 32'h0000_0000);
    @(posedge clk_sys_in);
    oe_n_pin <= 1'b0;
    repeat (60) @(posedge clk_sys_in);
    chk({31'h0, irq}, 32'h0000_0001);
    reg_rd(4'h2, 32'h0000_0000);
    give_verdict();
  end
endmodule : testbench

`default_nettype wire
